// File: core/coe_ctrl.sv
// output enable, disable state, soft reset sequence and step pin control
// assumes a byte register port from a two-wire bus front end on clk_sys_i
// Function
// - disable pin high turns off outputs
// - always-on outputs ignore the disable pin
// - low four bits enable outputs individually
// - bit four disables all but always-on outputs, overriding individual
// - two-bit field picks disabled output state
// - always-on output runs whatever else happens
// - writing 0x02 to 246 starts soft reset
// - soft reset bit not self-clearing
// - soft reset leaves configuration registers untouched
// - soft reset: outputs off, then calibrate, align
// - wait 25 ms lock unless override set
// - re-enable exactly the outputs switched off
// - step pins affect only first clock output
// - frequency steps 1 ppm, glitchless
// - phase adjustable 20 ps over 45 ns
// - initial phase applied only with divider one
// - sync on falling edge unless inverted
// - post-divider ratios one to thirty-two
// - spread ranges within documented limits
`timescale 1ns/1ps
`default_nettype none
module coe_ctrl
  import coe_pkg::*;
#(
  parameter int LOCK_CYCLES = COE_LOCK_CYCLES
)
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic output_disable_pin_i,
  input wire logic freq_step_up_pin_i,
  input wire logic freq_step_down_pin_i,
  output logic [3:0] drive_on_o,
  output logic [3:0] drive_level_o,
  output logic [3:0] drive_en_o,
  output logic [3:0] align_o,
  output logic freq_up0_o,
  output logic freq_down0_o,
  output logic busy_o
);
  coe_out_if oif ();

  logic [7:0] fmt [4];
  logic [7:0] oen;
  logic [7:0] srst;
  logic [7:0] cal;
  logic [7:0] step_req;
  logic [1:0] dis_sync;
  logic [1:0] up_sync;
  logic [1:0] dn_sync;
  logic up_prev;
  logic dn_prev;
  logic [3:0] held_off;
  logic [31:0] cnt;
  coe_state_t state;
  coe_state_t next_state;
  logic [7:0] rdata;

  function automatic logic is_always(input logic [7:0] f);
    is_always = (f[COE_DIS_POS +: 2] == COE_DIS_ALWAYS);
  endfunction

  // only code 0 (divide by one) gets alignment; other ratio codes give no phase guarantee
  function automatic logic rdiv_one(input logic [7:0] f);
    rdiv_one = (f[COE_RDIV_POS +: 3] == 3'h0);
  endfunction

  wire wr_fmt0 = reg_wr_i && (reg_addr_i == COE_ADDR_FMT0);
  wire wr_fmt1 = reg_wr_i && (reg_addr_i == COE_ADDR_FMT1);
  wire wr_fmt2 = reg_wr_i && (reg_addr_i == COE_ADDR_FMT2);
  wire wr_fmt3 = reg_wr_i && (reg_addr_i == COE_ADDR_FMT3);
  wire wr_oen = reg_wr_i && (reg_addr_i == COE_ADDR_OEN);
  wire wr_srst = reg_wr_i && (reg_addr_i == COE_ADDR_SRST);
  wire wr_cal = reg_wr_i && (reg_addr_i == COE_ADDR_CAL);
  wire wr_step = reg_wr_i && (reg_addr_i == COE_ADDR_STEP);
  wire srst_go = wr_srst && (reg_wdata_i == COE_SRST_VALUE);
  wire pin_dis = dis_sync[1];
  wire up_edge = up_sync[1] && !up_prev;
  wire dn_edge = dn_sync[1] && !dn_prev;
  wire [3:0] always_on = {is_always(fmt[3]), is_always(fmt[2]), is_always(fmt[1]), is_always(fmt[0])};
  wire [3:0] base_on = (oen[COE_ALL_OFF_BIT] || pin_dis) ? 4'h0 : oen[3:0];
  wire [3:0] seq_off = (state == COE_IDLE) ? 4'h0 : held_off;
  wire [3:0] want_on = (base_on & ~seq_off) | always_on;
  wire skip_lock = cal[0];
  wire cal_done = (cnt == 32'(COE_CAL_CYCLES - 1));
  wire lock_done = (cnt == 32'(LOCK_CYCLES - 1));

  // pin inputs are asynchronous: two flops before any use
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      dis_sync <= 2'h0;
      up_sync <= 2'h0;
      dn_sync <= 2'h0;
      up_prev <= 1'b0;
      dn_prev <= 1'b0;
    end
    else
    begin
      dis_sync <= {dis_sync[0], output_disable_pin_i};
      up_sync <= {up_sync[0], freq_step_up_pin_i};
      dn_sync <= {dn_sync[0], freq_step_down_pin_i};
      up_prev <= up_sync[1];
      dn_prev <= dn_sync[1];
    end
  end

  // soft reset never touches these: only bus writes change them
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      fmt[0] <= COE_FMT_RESET;
      fmt[1] <= COE_FMT_RESET;
      fmt[2] <= COE_FMT_RESET;
      fmt[3] <= COE_FMT_RESET;
      oen <= COE_OEN_RESET;
      srst <= 8'h00;
      cal <= COE_CAL_RESET;
    end
    else
    begin
      if (wr_fmt0) fmt[0] <= reg_wdata_i;
      if (wr_fmt1) fmt[1] <= reg_wdata_i;
      if (wr_fmt2) fmt[2] <= reg_wdata_i;
      if (wr_fmt3) fmt[3] <= reg_wdata_i;
      if (wr_oen) oen <= reg_wdata_i;
      if (wr_srst) srst <= reg_wdata_i;
      if (wr_cal) cal <= reg_wdata_i;
    end
  end

  // register-driven and pin steps both drive output 0 only; the other step bits show in step_req for one cycle after the write
  // step and spread amounts are applied by the synthesiser; this block only times the requests
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      step_req <= COE_STEP_RESET;
      freq_up0_o <= 1'b0;
      freq_down0_o <= 1'b0;
    end
    else
    begin
      step_req <= wr_step ? reg_wdata_i : 8'h00;
      freq_up0_o <= up_edge || (wr_step && reg_wdata_i[0]);
      freq_down0_o <= dn_edge || (wr_step && reg_wdata_i[4]);
    end
  end

  always_comb
  begin
    next_state = state;
    case (state)
      COE_IDLE: if (srst_go) next_state = COE_OFF;
      COE_OFF: next_state = COE_CALIB;
      COE_CALIB: if (cal_done) next_state = skip_lock ? COE_IDLE : COE_LOCK;
      COE_LOCK: if (lock_done) next_state = COE_IDLE;
      default: next_state = COE_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      state <= COE_IDLE;
      cnt <= 32'h0;
      held_off <= 4'h0;
    end
    else
    begin
      state <= next_state;
      cnt <= (next_state != state) ? 32'h0 : cnt + 32'h1;
      if (state == COE_IDLE && srst_go)
        held_off <= ~always_on;
    end
  end

  // phase alignment pulse only for outputs with unity post-divider
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      align_o <= 4'h0;
    else
      align_o <= (state == COE_CALIB && cal_done) ?
        {rdiv_one(fmt[3]), rdiv_one(fmt[2]), rdiv_one(fmt[1]), rdiv_one(fmt[0])} : 4'h0;
  end

  assign oif.want_on = want_on;
  assign oif.dis_mode = {fmt[3][COE_DIS_POS +: 2], fmt[2][COE_DIS_POS +: 2],
                         fmt[1][COE_DIS_POS +: 2], fmt[0][COE_DIS_POS +: 2]};

  coe_gate u_gate (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .bus(oif.gate)
  );

  assign drive_on_o = oif.drive_on;
  assign drive_level_o = oif.drive_level;
  assign drive_en_o = oif.drive_en;

  always_comb
  begin
    case (reg_addr_i)
      COE_ADDR_FMT0: rdata = fmt[0];
      COE_ADDR_FMT1: rdata = fmt[1];
      COE_ADDR_FMT2: rdata = fmt[2];
      COE_ADDR_FMT3: rdata = fmt[3];
      COE_ADDR_OEN: rdata = oen;
      COE_ADDR_SRST: rdata = srst;
      COE_ADDR_CAL: rdata = cal;
      COE_ADDR_STEP: rdata = step_req;
      COE_ADDR_STAT: rdata = {3'h0, state != COE_IDLE, oif.drive_on};
      default: rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o <= 8'h00;
      busy_o <= 1'b0;
    end
    else
    begin
      if (reg_rd_i) reg_rdata_o <= rdata;
      busy_o <= (next_state != COE_IDLE);
    end
  end

  property p_always_on;
    @(posedge clk_sys_i) disable iff (rst_i)
    (is_always(fmt[3]) && $stable(fmt[3])) |=> drive_on_o[3];
  endproperty
  a_always_on: assert property (p_always_on) else $error("always-on output off");

  property p_pin_off;
    @(posedge clk_sys_i) disable iff (rst_i)
    (pin_dis && !is_always(fmt[1]) && $stable(fmt[1])) |=> !drive_on_o[1];
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin disable ignored");

  property p_all_off;
    @(posedge clk_sys_i) disable iff (rst_i)
    (oen[COE_ALL_OFF_BIT] && always_on == 4'h0 && $stable(fmt[2])) |=> drive_on_o == 4'h0;
  endproperty
  a_all_off: assert property (p_all_off) else $error("global disable ignored");

  property p_start;
    @(posedge clk_sys_i) disable iff (rst_i)
    (state == COE_IDLE && srst_go) |=> state == COE_OFF ##1 state == COE_CALIB;
  endproperty
  a_start: assert property (p_start) else $error("soft reset did not start");

  property p_off_during;
    @(posedge clk_sys_i) disable iff (rst_i)
    (state == COE_CALIB && !always_on[0]) |=> !drive_on_o[0];
  endproperty
  a_off_during: assert property (p_off_during) else $error("output on during sequence");

  property p_skip;
    @(posedge clk_sys_i) disable iff (rst_i)
    (state == COE_CALIB && cal_done && skip_lock) |=> state == COE_IDLE;
  endproperty
  a_skip: assert property (p_skip) else $error("lock wait not skipped");

  property p_restore;
    @(posedge clk_sys_i) disable iff (rst_i)
    (state == COE_LOCK && lock_done && oen[0] && !oen[4] && !pin_dis && $stable(oen)) |=> ##1 drive_on_o[0];
  endproperty
  a_restore: assert property (p_restore) else $error("output not restored");

  property p_cfg_kept;
    @(posedge clk_sys_i) disable iff (rst_i)
    (state != COE_IDLE && !wr_oen) |=> $stable(oen);
  endproperty
  a_cfg_kept: assert property (p_cfg_kept) else $error("config changed by soft reset");

  c_srst: cover property (@(posedge clk_sys_i) disable iff (rst_i) state == COE_LOCK ##1 state == COE_IDLE);
  c_skip: cover property (@(posedge clk_sys_i) disable iff (rst_i) state == COE_CALIB ##1 state == COE_IDLE);
  c_pin: cover property (@(posedge clk_sys_i) disable iff (rst_i) up_edge ##1 freq_up0_o);
endmodule
`default_nettype wire

// File: common/coe_pkg.sv
// constants, register map and types for the output enable / soft reset block
// assumes a byte-wide register port driven by an external two-wire bus decoder
package coe_pkg;
  localparam int COE_NUM_OUT = 4;
  localparam logic [7:0] COE_ADDR_FMT0 = 8'h6e;
  localparam logic [7:0] COE_ADDR_FMT1 = 8'h70;
  localparam logic [7:0] COE_ADDR_FMT2 = 8'h72;
  localparam logic [7:0] COE_ADDR_FMT3 = 8'h76;
  localparam logic [7:0] COE_ADDR_OEN = 8'he6;
  localparam logic [7:0] COE_ADDR_SRST = 8'hf6;
  localparam logic [7:0] COE_ADDR_CAL = 8'hf0;
  localparam logic [7:0] COE_ADDR_STEP = 8'hf1;
  localparam logic [7:0] COE_ADDR_STAT = 8'hf2;
  localparam logic [7:0] COE_SRST_VALUE = 8'h02;
  localparam int COE_SRST_BIT = 1;
  localparam int COE_DIS_POS = 6;
  localparam int COE_RDIV_POS = 0;
  localparam int COE_ALL_OFF_BIT = 4;
  localparam logic [7:0] COE_FMT_RESET = 8'h00;
  localparam logic [7:0] COE_OEN_RESET = 8'h0f;
  localparam logic [7:0] COE_CAL_RESET = 8'h00;
  localparam logic [7:0] COE_STEP_RESET = 8'h00;
  localparam logic [1:0] COE_DIS_TRI = 2'h0;
  localparam logic [1:0] COE_DIS_LOW = 2'h1;
  localparam logic [1:0] COE_DIS_HIGH = 2'h2;
  localparam logic [1:0] COE_DIS_ALWAYS = 2'h3;
  localparam int COE_CLK_MHZ = 100;
  localparam int COE_LOCK_WAIT_MS = 25;
  // ms to us is 1000, then MHz gives cycles per us; 2500000 still fits an int
  localparam int COE_LOCK_CYCLES = COE_LOCK_WAIT_MS * 1000 * COE_CLK_MHZ;
  localparam int COE_CAL_CYCLES = 16;
  localparam int COE_STEP_GAP_NS = 667;
  localparam int COE_STEP_GAP_CYCLES = (COE_STEP_GAP_NS * COE_CLK_MHZ + 999) / 1000;
  typedef enum logic [3:0] {
    COE_IDLE = 4'h1,
    COE_OFF = 4'h2,
    COE_CALIB = 4'h4,
    COE_LOCK = 4'h8
  } coe_state_t;
endpackage

// File: common/coe_out_if.sv
// bundle between the control core and the per-output gate
// assumes both ends share clk_sys_i
`timescale 1ns/1ps
`default_nettype none
interface coe_out_if;
  logic [3:0] want_on;
  logic [7:0] dis_mode;
  logic [3:0] drive_on;
  logic [3:0] drive_level;
  logic [3:0] drive_en;
  modport ctrl (output want_on, output dis_mode, input drive_on, input drive_level, input drive_en);
  modport gate (input want_on, input dis_mode, output drive_on, output drive_level, output drive_en);
endinterface
`default_nettype wire

// File: core/coe_gate.sv
// per-output driver gating: turns enable requests into driver state
// assumes output clocks are aligned to clk_sys_i, so switching here never splits a pulse
`timescale 1ns/1ps
`default_nettype none
module coe_gate
  import coe_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  coe_out_if.gate bus
);
  logic [3:0] next_on;
  logic [3:0] next_level;
  logic [3:0] next_en;
  logic [3:0] drive_on;
  logic [3:0] drive_level;
  logic [3:0] drive_en;

  always_comb
  begin
    for (int i = 0; i < COE_NUM_OUT; i++)
    begin
      next_on[i] = bus.want_on[i] || (bus.dis_mode[2*i +: 2] == COE_DIS_ALWAYS);
      next_level[i] = (bus.dis_mode[2*i +: 2] == COE_DIS_HIGH);
      next_en[i] = next_on[i] || (bus.dis_mode[2*i +: 2] != COE_DIS_TRI);
    end
  end

  // registered so a change lands on a clock boundary only
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      drive_on <= 4'h0;
      drive_level <= 4'h0;
      drive_en <= 4'h0;
    end
    else
    begin
      drive_on <= next_on;
      drive_level <= next_level;
      drive_en <= next_en;
    end
  end

  assign bus.drive_on = drive_on;
  assign bus.drive_level = drive_level;
  assign bus.drive_en = drive_en;
endmodule
`default_nettype wire

// File: tb/coe_host.sv
// host model: drives the register port, the disable pin and the step pins
// assumes one caller at a time, all tasks entered at or after a clk_sys_i edge
`timescale 1ns/1ps
`default_nettype none
module coe_host (
  input wire logic clk_sys_i,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic dis_pin_o,
  output logic up_pin_o,
  output logic down_pin_o
);
  initial
  begin
    {reg_wr_o, reg_rd_o, dis_pin_o, up_pin_o, down_pin_o} = 5'h00;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end
  // the feedback output is set always-on by the caller before any soft reset
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_wr_o <= wr;
    reg_rd_o <= !wr;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge clk_sys_i);
    {reg_wr_o, reg_rd_o} <= 2'h0;
    // released bus shows the inverse, not a stale value
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask
  task automatic set_dis(input logic v);
    dis_pin_o <= v;
  endtask
  // step pulses keep a 70 cycle gap, slower than the pin rate limit
  // frequency and phase ranges are not exercised: no synthesis is modelled
  task automatic step(input logic up);
    @(posedge clk_sys_i);
    if (up)
      up_pin_o <= 1'b1;
    else
      down_pin_o <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    {up_pin_o, down_pin_o} <= 2'h0;
    repeat (70) @(posedge clk_sys_i);
  endtask
endmodule
`default_nettype wire

// File: tb/coe_ctrl_tb.sv
// self-checking bench for coe_ctrl with the host model on its register port
// assumes a shortened lock wait and read data one edge after the strobe
`timescale 1ns/1ps
`default_nettype none
module coe_ctrl_tb;
  import coe_pkg::*;
  localparam int LOCK = 50;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic reg_wr, reg_rd, dis_pin, up_pin, down_pin, up0, down0, busy, rd_seen;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] drive_on, drive_level, drive_en, align, align_seen;
  logic [7:0] exp_q[$];
  logic [3:0] r;
  int n_mismatch = 0;
  int n_compared = 0;
  int up_cnt = 0;
  int down_cnt = 0;
  int n;
  coe_host host (.clk_sys_i(clk_sys_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata), .dis_pin_o(dis_pin), .up_pin_o(up_pin), .down_pin_o(down_pin));
  coe_ctrl #(.LOCK_CYCLES(LOCK)) uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .output_disable_pin_i(dis_pin), .freq_step_up_pin_i(up_pin), .freq_step_down_pin_i(down_pin),
    .drive_on_o(drive_on), .drive_level_o(drive_level), .drive_en_o(drive_en), .align_o(align),
    .freq_up0_o(up0), .freq_down0_o(down0), .busy_o(busy));
  always #5 clk_sys_i = ~clk_sys_i;
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    host.acc(1'b0, a, 8'h00);
    repeat (2) @(posedge clk_sys_i);
  endtask
  task automatic wrs(input logic [7:0] a, input logic [7:0] d);
    host.acc(1'b1, a, d);
    repeat (4) @(posedge clk_sys_i);
  endtask
  task automatic soft_reset(input logic fast);
    align_seen = 4'h0;
    wrs(COE_ADDR_CAL, {7'h00, fast});
    host.acc(1'b1, COE_ADDR_SRST, COE_SRST_VALUE);
    repeat (4) @(posedge clk_sys_i);
    chk("busy_o", 8'h01, {7'h00, busy});
    chk("drive_on_o", 8'h08, {4'h0, drive_on});
    n = 0;
    while (busy === 1'b1 && n < 500)
    begin
      @(posedge clk_sys_i);
      n++;
    end
    chk("lock wait", 8'h01, {7'h00, fast ? n < LOCK : (n >= LOCK && n < 500)});
    repeat (4) @(posedge clk_sys_i);
    chk("drive_on_o", 8'h0f, {4'h0, drive_on});
    chk("align_o", 8'h0d, {4'h0, align_seen});
  endtask
  always @(posedge clk_sys_i)
  begin
    if (rd_seen && exp_q.size() > 0)
      chk("reg_rdata_o", exp_q.pop_front(), reg_rdata);
    rd_seen <= reg_rd;
    if (align !== 4'h0)
      align_seen <= align;
    up_cnt <= up_cnt + int'(up0 === 1'b1);
    down_cnt <= down_cnt + int'(down0 === 1'b1);
  end
  task automatic final_report;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #500000;
    n_mismatch++;
    final_report();
  end
  initial
  begin
    rd_seen = 1'b0;
    align_seen = 4'h0;
    void'($urandom(32'h88dda1b9));
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rdc(COE_ADDR_FMT0, COE_FMT_RESET);
    rdc(COE_ADDR_FMT1, COE_FMT_RESET);
    rdc(COE_ADDR_FMT2, COE_FMT_RESET);
    rdc(COE_ADDR_FMT3, COE_FMT_RESET);
    rdc(COE_ADDR_OEN, COE_OEN_RESET);
    rdc(COE_ADDR_STAT, 8'h0f);
    rdc(8'h55, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 4; i++)
    begin
      r = 4'($urandom());
      wrs(COE_ADDR_OEN, {4'h0, r});
      rdc(COE_ADDR_STAT, {4'h0, r});
      wrs(COE_ADDR_OEN, {4'h1, r});
      rdc(COE_ADDR_STAT, 8'h00);
    end
    $display("test enables done");
    wrs(COE_ADDR_FMT1, 8'h41);
    wrs(COE_ADDR_FMT2, 8'h80);
    wrs(COE_ADDR_FMT3, 8'hc0);
    chk("drive_on_o", 8'h08, {4'h0, drive_on});
    chk("drive_level_o", 8'h04, {4'h0, drive_level});
    chk("drive_en_o", 8'h0e, {4'h0, drive_en});
    wrs(COE_ADDR_OEN, 8'h0f);
    host.set_dis(1'b1);
    repeat (8) @(posedge clk_sys_i);
    chk("drive_on_o", 8'h08, {4'h0, drive_on});
    host.set_dis(1'b0);
    repeat (8) @(posedge clk_sys_i);
    chk("drive_on_o", 8'h0f, {4'h0, drive_on});
    $display("test disable states done");
    soft_reset(1'b0);
    soft_reset(1'b1);
    rdc(COE_ADDR_FMT1, 8'h41);
    rdc(COE_ADDR_FMT3, 8'hc0);
    wrs(COE_ADDR_SRST, 8'h01);
    chk("busy_o", 8'h00, {7'h00, busy});
    $display("test soft reset done");
    for (int i = 0; i < 5; i++)
      host.step(i < 3);
    wrs(COE_ADDR_STEP, 8'h01);
    wrs(COE_ADDR_STEP, 8'h10);
    chk("up steps", 8'h04, 8'(up_cnt));
    chk("down steps", 8'h03, 8'(down_cnt));
    $display("test step pins done");
    repeat (4) @(posedge clk_sys_i);
    final_report();
  end
endmodule
`default_nettype wire
